// File: shared/erd_pkg.sv
// What this block does
// - 0000: retries, then correction, silent
// - 0001: retries, no correction, silent
// - 0100: retries, correction, report recovered
// - 0101: retries, no correction, report
// - 0110: retries, correction, report, stop
// - 0111: retries, no correction, report, stop
// - 1000: correction first, silent
// - 1100: correction first, report
// - 1110: correction first, report, stop
// - page two: code 02h, length 0Ah
// - inactivity limit counts 100 us units
// - accept limits 1 through 650
// - zero limit means stay connected forever
// - byte two bits three to zero
// - continuous read disables retries and correction
`default_nettype none
package erd_pkg;
  // ---------------------------------------------------------------
  // page layout
  // ---------------------------------------------------------------
  localparam logic [5:0] ERD_PAGE_RECOVERY = 6'h01;
  localparam logic [5:0] ERD_PAGE_DISCON = 6'h02;
  localparam logic [7:0] ERD_DISCON_LEN = 8'h0a;
  localparam int ERD_BIT_CONT_READ = 4;
  localparam int ERD_BIT_EARLY = 3;
  localparam int ERD_BIT_POST = 2;
  localparam int ERD_BIT_STOP = 1;
  localparam int ERD_BIT_NOCORR = 0;
  localparam logic [15:0] ERD_LIMIT_MAX = 16'h028a;
  localparam logic [15:0] ERD_LIMIT_NONE = 16'h0000;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int ERD_CLK_MHZ = 100;
  localparam int ERD_TICK_US = 100;
  localparam int ERD_TICK_CYCLES = ERD_TICK_US * ERD_CLK_MHZ;
  localparam logic [13:0] ERD_TICK_LAST = 14'(ERD_TICK_CYCLES - 1);
  // ---------------------------------------------------------------
  // recovery policy
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ERD_M_RETRY_CORR,
    ERD_M_NO_CORR,
    ERD_M_REPORT,
    ERD_M_REPORT_NOCORR,
    ERD_M_REPORT_STOP,
    ERD_M_REPORT_NOCORR_STOP,
    ERD_M_EARLY,
    ERD_M_EARLY_REPORT,
    ERD_M_EARLY_REPORT_STOP,
    ERD_M_CONTINUOUS,
    ERD_M_INVALID
  } erd_mode_e;
endpackage : erd_pkg
`default_nettype wire

// File: rtl/erd_tick_timer.sv
`timescale 1ns/100ps
`default_nettype none
module erd_tick_timer
  import erd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic restart,
  // output
  output logic tick
);
  logic [13:0] cnt_q;
  logic [13:0] cnt_d;
  logic wrap;
  // ---------------------------------------------------------------
  // 100 us prescaler
  // ---------------------------------------------------------------
  // 100 us ticks
  assign wrap = (cnt_q == ERD_TICK_LAST);
  assign cnt_d = (restart || wrap) ? 14'h0000 : cnt_q + 14'h0001;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 14'h0000;
      tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick <= wrap && !restart;
    end
  end
endmodule : erd_tick_timer
`default_nettype wire

// File: rtl/erd_mode_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module erd_mode_decoder
  import erd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // recovery page byte two
  input wire logic recovery_load,
  input wire logic [7:0] recovery_ctrl,
  // disconnect page
  input wire logic discon_load,
  input wire logic [5:0] discon_page_code,
  input wire logic [7:0] discon_page_len,
  input wire logic [7:0] buffer_full_ratio,
  input wire logic [7:0] buffer_empty_ratio,
  input wire logic [15:0] bus_inactivity_limit,
  input wire logic [15:0] disconnect_time_limit,
  input wire logic [15:0] connect_time_limit,
  // bus state
  input wire logic bus_connected,
  input wire logic bus_activity,
  // policy
  output logic retries_enabled,
  output logic correction_enabled,
  output logic correct_before_retry,
  output logic report_recovered,
  output logic stop_on_error,
  output logic mode_invalid,
  output logic [3:0] mode_code,
  // disconnect page status
  output logic discon_page_error,
  output logic [15:0] inactivity_limit,
  output logic disconnect_request
);
  // ---------------------------------------------------------------
  // recovery bit decode
  // ---------------------------------------------------------------
  logic [3:0] bits_q;
  logic cont_q;
  logic [3:0] bits_in;
  logic cont_in;
  erd_mode_e mode;
  assign bits_in = {recovery_ctrl[ERD_BIT_EARLY], recovery_ctrl[ERD_BIT_POST],
                    recovery_ctrl[ERD_BIT_STOP], recovery_ctrl[ERD_BIT_NOCORR]};
  assign cont_in = recovery_ctrl[ERD_BIT_CONT_READ];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bits_q <= 4'h0;
      cont_q <= 1'b0;
    end else if (recovery_load) begin
      bits_q <= bits_in;
      cont_q <= cont_in;
    end
  end

  always_comb begin
    mode = ERD_M_INVALID;
    if (cont_q) begin
      mode = ERD_M_CONTINUOUS;
    end else begin
      unique case (bits_q)
        4'h0: mode = ERD_M_RETRY_CORR;
        4'h1: mode = ERD_M_NO_CORR;
        4'h4: mode = ERD_M_REPORT;
        4'h5: mode = ERD_M_REPORT_NOCORR;
        4'h6: mode = ERD_M_REPORT_STOP;
        4'h7: mode = ERD_M_REPORT_NOCORR_STOP;
        4'h8: mode = ERD_M_EARLY;
        4'hc: mode = ERD_M_EARLY_REPORT;
        4'he: mode = ERD_M_EARLY_REPORT_STOP;
        default: mode = ERD_M_INVALID;
      endcase
    end
  end

  logic pol_retry, pol_corr, pol_early, pol_report, pol_stop;
  assign pol_retry = (mode != ERD_M_CONTINUOUS) && (mode != ERD_M_INVALID);
  assign pol_corr = (mode == ERD_M_RETRY_CORR) || (mode == ERD_M_REPORT) ||
                    (mode == ERD_M_REPORT_STOP) || (mode == ERD_M_EARLY) ||
                    (mode == ERD_M_EARLY_REPORT) || (mode == ERD_M_EARLY_REPORT_STOP);
  assign pol_early = (mode == ERD_M_EARLY) || (mode == ERD_M_EARLY_REPORT) ||
                     (mode == ERD_M_EARLY_REPORT_STOP);
  assign pol_report = (mode == ERD_M_REPORT) || (mode == ERD_M_REPORT_NOCORR) ||
                      (mode == ERD_M_REPORT_STOP) || (mode == ERD_M_REPORT_NOCORR_STOP) ||
                      (mode == ERD_M_EARLY_REPORT) || (mode == ERD_M_EARLY_REPORT_STOP);
  assign pol_stop = (mode == ERD_M_REPORT_STOP) || (mode == ERD_M_REPORT_NOCORR_STOP) ||
                    (mode == ERD_M_EARLY_REPORT_STOP);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      retries_enabled <= 1'b1;
      correction_enabled <= 1'b1;
      correct_before_retry <= 1'b0;
      report_recovered <= 1'b0;
      stop_on_error <= 1'b0;
      mode_invalid <= 1'b0;
      mode_code <= 4'h0;
    end else begin
      retries_enabled <= pol_retry;
      correction_enabled <= pol_corr;
      correct_before_retry <= pol_early;
      report_recovered <= pol_report;
      stop_on_error <= pol_stop;
      mode_invalid <= (mode == ERD_M_INVALID);
      mode_code <= mode;
    end
  end

  // ---------------------------------------------------------------
  // disconnect page check
  // ---------------------------------------------------------------
  logic hdr_bad, fields_bad, limit_bad;
  assign hdr_bad = (discon_page_code != ERD_PAGE_DISCON) || (discon_page_len != ERD_DISCON_LEN);
  assign fields_bad = (buffer_full_ratio != 8'h00) || (buffer_empty_ratio != 8'h00) ||
                      (disconnect_time_limit != 16'h0000) || (connect_time_limit != 16'h0000);
  assign limit_bad = bus_inactivity_limit > ERD_LIMIT_MAX;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      discon_page_error <= 1'b0;
      inactivity_limit <= ERD_LIMIT_NONE;
    end else if (discon_load) begin
      discon_page_error <= hdr_bad || fields_bad || limit_bad;
      if (!hdr_bad && !limit_bad) begin
        inactivity_limit <= bus_inactivity_limit;
      end
    end
  end

  // ---------------------------------------------------------------
  // inactivity watchdog
  // ---------------------------------------------------------------
  logic restart, tick;
  logic [15:0] idle_q;
  logic [15:0] idle_d;
  logic limit_hit;
  assign restart = bus_activity || !bus_connected;

  erd_tick_timer u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .restart(restart),
    .tick(tick)
  );

  assign limit_hit = (inactivity_limit != ERD_LIMIT_NONE) && (idle_q >= inactivity_limit);
  assign idle_d = restart ? 16'h0000 : ((tick && !limit_hit) ? idle_q + 16'h0001 : idle_q);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_q <= 16'h0000;
      disconnect_request <= 1'b0;
    end else begin
      idle_q <= idle_d;
      disconnect_request <= limit_hit && !restart;
    end
  end
endmodule : erd_mode_decoder
`default_nettype wire

// File: bench/erd_initiator.sv
`timescale 1ns/100ps
`default_nettype none
module erd_initiator (
  // fault selection
  input wire logic [1:0] fault,
  // disconnect page fields
  output logic [5:0] discon_page_code,
  output logic [7:0] discon_page_len,
  output logic [7:0] buffer_full_ratio,
  output logic [7:0] buffer_empty_ratio,
  output logic [15:0] disconnect_time_limit,
  output logic [15:0] connect_time_limit
);
  assign discon_page_code = (fault == 2'h1) ? 6'h03 : 6'h02;
  assign discon_page_len = 8'h0a;
  assign buffer_full_ratio = {7'h00, fault == 2'h2};
  assign buffer_empty_ratio = {7'h00, fault == 2'h3};
  assign disconnect_time_limit = {15'h0000, fault == 2'h3};
  assign connect_time_limit = {15'h0000, fault == 2'h3};
endmodule : erd_initiator
`default_nettype wire

// File: bench/erd_mode_decoder_props.sv
`timescale 1ns/100ps
`default_nettype none
module erd_mode_decoder_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // loads and bus
  input wire logic recovery_load,
  input wire logic [7:0] recovery_ctrl,
  input wire logic discon_load,
  input wire logic [15:0] bus_inactivity_limit,
  input wire logic bus_activity,
  // policy and status
  input wire logic retries_enabled,
  input wire logic correction_enabled,
  input wire logic correct_before_retry,
  input wire logic report_recovered,
  input wire logic stop_on_error,
  input wire logic mode_invalid,
  input wire logic [3:0] mode_code,
  input wire logic discon_page_error,
  input wire logic [15:0] inactivity_limit,
  input wire logic disconnect_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic [4:0] rc = recovery_ctrl[4:0];
  wire logic ld = recovery_load;
  wire logic inv = !rc[4] && (rc[3:0] inside {4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'hd, 4'hf});
  property p_report; ld && rc == 5'h04 |-> ##2 report_recovered && correction_enabled && mode_code == 4'h2; endproperty
  property p_stop; ld && rc == 5'h07 |-> ##2 stop_on_error && report_recovered && !correction_enabled; endproperty
  property p_early; ld && rc == 5'h0c |-> ##2 correct_before_retry && report_recovered && mode_code == 4'h7; endproperty
  property p_invalid; ld && inv |-> ##2 mode_invalid && !retries_enabled && !correction_enabled; endproperty
  property p_cont; ld && rc[4] |-> ##2 !retries_enabled && !correction_enabled && mode_code == 4'h9; endproperty
  property p_range; discon_load && bus_inactivity_limit > 16'h028a |=> discon_page_error && $stable(inactivity_limit);
  endproperty
  property p_zero; inactivity_limit == 16'h0000 && $past(inactivity_limit) == 16'h0000 |-> !disconnect_request;
  endproperty
  property p_idle; bus_activity |=> !disconnect_request; endproperty
  a_report: assert property (p_report) else $error("report mode wrong");
  a_stop: assert property (p_stop) else $error("stop mode wrong");
  a_early: assert property (p_early) else $error("early mode wrong");
  a_invalid: assert property (p_invalid) else $error("invalid mode not flagged");
  a_cont: assert property (p_cont) else $error("continuous read wrong");
  a_range: assert property (p_range) else $error("limit range not refused");
  a_zero: assert property (p_zero) else $error("request with zero limit");
  a_idle: assert property (p_idle) else $error("request kept after activity");
  c_invalid: cover property (ld && inv);
  c_cont: cover property (ld && rc[4]);
  c_request: cover property (disconnect_request);
endmodule : erd_mode_decoder_props
bind erd_mode_decoder erd_mode_decoder_props erd_mode_decoder_props_inst (.*);
`default_nettype wire

// File: bench/tb_erd_mode_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module tb_erd_mode_decoder;
  logic clk = 1'b0, rst_n = 1'b0, recovery_load = 1'b0, discon_load = 1'b0, bus_connected = 1'b1, bus_activity = 1'b0;
  logic [7:0] recovery_ctrl = 8'h00;
  logic [1:0] fault = 2'h0;
  logic [15:0] bus_inactivity_limit = 16'h0000;
  logic [5:0] discon_page_code;
  logic [7:0] discon_page_len, buffer_full_ratio, buffer_empty_ratio;
  logic [15:0] disconnect_time_limit, connect_time_limit, inactivity_limit;
  logic retries_enabled, correction_enabled, correct_before_retry, report_recovered, stop_on_error, mode_invalid;
  logic discon_page_error, disconnect_request, v;
  logic [3:0] mode_code;
  logic [3:0] mc [16] = '{4'h0, 4'h1, 4'ha, 4'ha, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'ha, 4'ha, 4'h7, 4'ha, 4'h8, 4'ha};
  int errors = 0, cmp_count = 0, cyc = 0, n = 0;
  erd_initiator erd_initiator_inst (.*);
  erd_mode_decoder erd_mode_decoder_inst (.*);
  always #5 clk = ~clk;
  task conclude;
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task rec(input logic [7:0] c, input logic [3:0] code, input logic [5:0] bits);
    @(posedge clk) recovery_ctrl <= c;
    recovery_load <= 1'b1;
    @(posedge clk) recovery_load <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("mode", {12'h000, mode_code}, {12'h000, code});
    chk("policy", {10'h000, retries_enabled, correction_enabled, correct_before_retry, report_recovered,
        stop_on_error, mode_invalid}, {10'h000, bits});
  endtask : rec
  task dis(input logic [1:0] f, input logic [15:0] lim, input logic err, input logic [15:0] exp_lim);
    @(posedge clk) fault <= f;
    bus_inactivity_limit <= lim;
    discon_load <= 1'b1;
    @(posedge clk) discon_load <= 1'b0;
    @(posedge clk) #1;
    chk("page_error", {15'h0000, discon_page_error}, {15'h0000, err});
    chk("limit", inactivity_limit, exp_lim);
  endtask : dis
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 45000) begin
      errors = errors + 1;
      conclude();
    end
  end
  initial begin
    repeat (15) @(posedge clk);
    #1 chk("reset", {6'h00, mode_code, retries_enabled, correction_enabled, correct_before_retry, report_recovered,
        stop_on_error, mode_invalid}, {6'h00, 4'h0, 6'b110000});
    chk("reset_page", {inactivity_limit[13:0], discon_page_error, disconnect_request}, 16'h0000);
    @(posedge clk) rst_n <= 1'b1;
    for (int p = 0; p < 16; p++) begin
      v = mc[p] !== 4'ha;
      rec(8'(p), mc[p], {v, v & !p[0], v & p[3], v & p[2], v & p[1], !v});
    end
    rec(8'he4, 4'h2, 6'b110100);
    rec(8'h1e, 4'h9, 6'b000000);
    dis(2'h0, 16'h028a, 1'b0, 16'h028a);
    dis(2'h0, 16'h028b, 1'b1, 16'h028a);
    dis(2'h1, 16'h0005, 1'b1, 16'h028a);
    dis(2'h2, 16'h0007, 1'b1, 16'h0007);
    dis(2'h3, 16'h0009, 1'b1, 16'h0009);
    dis(2'h0, 16'h0001, 1'b0, 16'h0001);
    @(posedge clk) bus_activity <= 1'b1;
    @(posedge clk) bus_activity <= 1'b0;
    while (disconnect_request !== 1'b1 && n < 10100) begin
      @(posedge clk) #1;
      n++;
    end
    chk("idle_time", {15'h0000, n >= 9999 && n <= 10004}, 16'h0001);
    @(posedge clk) bus_activity <= 1'b1;
    @(posedge clk) bus_activity <= 1'b0;
    #1 chk("request", {15'h0000, disconnect_request}, 16'h0000);
    @(posedge clk) bus_connected <= 1'b0;
    repeat (10100) @(posedge clk);
    #1 chk("disconnected", {15'h0000, disconnect_request}, 16'h0000);
    @(posedge clk) bus_connected <= 1'b1;
    dis(2'h0, 16'h0000, 1'b0, 16'h0000);
    repeat (12000) @(posedge clk);
    #1 chk("no_limit", {15'h0000, disconnect_request}, 16'h0000);
    conclude();
  end
endmodule : tb_erd_mode_decoder
`default_nettype wire
